/* File: cml_board.sv */
// Board-side logic around the macrocell array: dedicated and I/O pins.
// Assumes the bench calls its tasks from one process on clk_sys.
`timescale 1ns/1ps
module cml_board
  import cml_pkg::*;
(
  input  wire logic [NUM_IO-1:0]  io_out,
  input  wire logic [NUM_IO-1:0]  io_oe,
  input  wire logic               clk_sys,
  output logic      [NUM_DED-1:0] ded_pin,
  output logic      [NUM_IO-1:0]  io_in
);
  logic [NUM_IO-1:0] drv;

  // Pins start low so the array sees known levels from time zero.
  initial begin
    ded_pin = 4'h0;
    drv     = 64'h0;
  end

  // A pin the array drives shows the array's level; the board lets go.
  assign io_in = (io_oe & io_out) | (~io_oe & drv);

  task automatic set_io(input int i, input logic v);
    @(posedge clk_sys);
    drv[i] <= v;
  endtask : set_io

  task automatic set_ded(input int i, input logic v);
    @(posedge clk_sys);
    ded_pin[i] <= v;
  endtask : set_ded

  // Levels stand four cycles so the synchroniser never misses an edge.
  task automatic pulse(input int i);
    set_ded(i, 1'b1);
    repeat (3) @(posedge clk_sys);
    set_ded(i, 1'b0);
    repeat (3) @(posedge clk_sys);
  endtask : pulse
endmodule : cml_board

/* File: cml_macrocell.sv */
// One macrocell: product terms, sum logic and the storage element.
// Assumes synchronised dedicated inputs and registered bus inputs.
`timescale 1ns/1ps
module cml_macrocell
  import cml_pkg::*;
(
  input  wire logic                         clk_sys,
  input  wire logic                         rst_n,
  input  wire cml_cfg_t                     cfg,
  input  wire logic [BLK_IN-1:0]            blk_in,
  input  wire logic [NUM_PT*PT_STRIDE-1:0]  masks,
  input  wire logic [NUM_DED-1:0]           ded,
  input  wire logic                         pin,
  input  wire logic                         chain_in,
  output cml_mc_out_t                       res
);
  logic [NUM_PT-1:0] pt;
  logic or_sum, xr, xb, d, clk_sig, clk_prev, rise, ce_ok, clr_on, pre_on, q;
  logic gclr, next_q;

  // Each term ANDs the mask-selected true and inverted columns of all inputs.
  for (genvar p = 0; p < NUM_PT; p++) begin : g_pt
    logic [PT_W-1:0] m;
    assign m = masks[p*PT_STRIDE +: PT_W];
    assign pt[p] = (&(~m[BLK_IN-1:0] | blk_in)) &
                   (&(~m[PT_W-1:BLK_IN] | ~blk_in));
  end

  // Sum and polarity path.
  assign or_sum = (|(pt & cfg.or_en)) | (cfg.casc_en & chain_in);
  always_comb begin
    unique case (cfg.xor_sel)
      CML_XOR_HIGH: xb = 1'b1;
      CML_XOR_PT:   xb = pt[cfg.xor_pt];
      default:      xb = 1'b0;
    endcase
    unique case (cfg.d_src)
      CML_D_PT:  d = pt[cfg.d_pt];
      CML_D_PIN: d = pin;
      default:   d = or_sum ^ xb;
    endcase
  end
  assign xr = or_sum ^ xb;

  // Clock, enable and asynchronous controls; any dedicated input may serve.
  assign clk_sig = cfg.clk_src[2] ? pt[cfg.clk_pt]
                                  : ded[cfg.clk_src[1:0]];
  assign ce_ok = !(cfg.ce_en && !cfg.clk_src[2]) || pt[cfg.clk_pt];
  assign rise  = clk_sig & ~clk_prev;
  assign gclr  = ded[cfg.gclr_pin];
  always_comb begin
    unique case (cfg.async_reset_select)
      CML_RST_GCLR: clr_on = gclr;
      CML_RST_PT:   clr_on = pt[cfg.rst_pt];
      CML_RST_BOTH: clr_on = gclr | pt[cfg.rst_pt];
      CML_RST_OFF:  clr_on = 1'b0;
    endcase
  end
  assign pre_on = cfg.async_preset_select & pt[cfg.preset_pt];

  // T and JK reuse the selected data d; K and R come from the aux term.
  always_comb begin
    unique case (cfg.ff_mode)
      CML_FF_D:  next_q = d;
      CML_FF_T:  next_q = q ^ d;
      CML_FF_JK: next_q = (d & ~q) | (~pt[cfg.aux_pt] & q);
      CML_FF_SR: next_q = d | (~pt[cfg.aux_pt] & q);
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) clk_prev <= 1'b0;
    else clk_prev <= clk_sig;
  end

  // Controls are levels sampled by clk_sys, so they act within one cycle.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) q <= 1'b0;
    else if (clr_on) q <= 1'b0;
    else if (pre_on) q <= 1'b1;
    else if (cfg.latch) q <= clk_sig ? d : q;
    else if (rise && ce_ok) q <= next_q;
  end

  assign res.chain = or_sum;
  assign res.fold  = ~pt[cfg.fold_pt];
  assign res.comb  = xr;
  assign res.q     = q;
  assign res.out   = cfg.out_reg ? q : xr;
  assign res.fb    = cfg.fb_reg ? q : xr;

  chk_reset_wins: assert property (@(posedge clk_sys)
    disable iff (!rst_n) clr_on |=> !q)
    else $error("reset did not clear the register");
  chk_preset_sets: assert property (@(posedge clk_sys)
    disable iff (!rst_n) (pre_on && !clr_on) |=> q)
    else $error("preset did not set the register");
  chk_ce_blocks: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    (rise && !ce_ok && !clr_on && !pre_on && !cfg.latch) |=> $stable(q))
    else $error("disabled clock edge changed the register");
  chk_d_edge: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    (rise && ce_ok && !clr_on && !pre_on && !cfg.latch &&
     cfg.ff_mode == CML_FF_D) |=> q == $past(d))
    else $error("rising edge did not load data");
  chk_no_edge: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    (!rise && !clr_on && !pre_on && !cfg.latch) |=> $stable(q))
    else $error("register changed without a rising edge");
  cov_both_ctl: cover property (@(posedge clk_sys) disable iff (!rst_n)
    clr_on && pre_on);
  cov_latch: cover property (@(posedge clk_sys) disable iff (!rst_n)
    cfg.latch && clk_sig && d ##1 q);
endmodule : cml_macrocell

/* File: cml_pkg.sv */
// Shared sizes, register map and macrocell configuration layout.
// Assumes one clk_sys domain and a Wishbone classic register slave.
// Notes on behaviour
// - Product terms see block and regional signals.
// - Term select mux routes five terms.
// - Global bus: all pins plus 64 feedbacks.
// - Switch matrix picks up to 40 signals.
// - OR sums five terms; chain reaches 40.
// - XOR operand: term, high or low.
// - Data from XOR, own term or pin.
// - D, T, JK, SR and transparent latch.
// - Clock from global input or term, rising.
// - Low enable term blocks global clock edges.
// - Reset: global clear, term, both, none.
// - Preset: term or none.
// - Output and feedback independently registered or not.
// - Output enable from pins, I/O or macrocells.
// - Inverted foldback term shared by four macrocells.
// - Dedicated inputs chosen per macrocell as controls.
// - 16-bit signature readable despite security.
package cml_pkg;
  localparam int NUM_MC     = 64;
  localparam int NUM_IO     = 64;
  localparam int NUM_DED    = 4;
  localparam int MC_PER_BLK = 16;
  localparam int NUM_BLK    = NUM_MC / MC_PER_BLK;
  localparam int NUM_PT     = 5;
  localparam int SW_SEL     = 40;
  localparam int REG_MC     = 4;
  localparam int BLK_IN     = SW_SEL + REG_MC;
  localparam int PT_W       = 2 * BLK_IN;
  localparam int PT_STRIDE  = 96;
  localparam int PT_WPM     = NUM_PT * PT_STRIDE / 32;
  localparam int CHAIN_LEN  = 8;
  localparam int GBUS_W     = NUM_IO + NUM_MC + NUM_DED;
  localparam logic [7:0]  GBUS_MAX  = 8'h83;
  // Word addresses; byte address is four times these.
  localparam logic [13:0] SIG_W     = 14'h0000;
  localparam logic [13:0] CTRL_W    = 14'h0001;
  localparam logic [13:0] DED_W     = 14'h0002;
  localparam logic [13:0] IO_LO_W   = 14'h0004;
  localparam logic [13:0] IO_HI_W   = 14'h0005;
  localparam logic [13:0] FB_LO_W   = 14'h0006;
  localparam logic [13:0] FB_HI_W   = 14'h0007;
  localparam logic [13:0] SW_WBASE  = 14'h0400;
  localparam logic [13:0] SW_WORDS  = 14'h00A0;
  localparam logic [13:0] CFG_WBASE = 14'h0800;
  localparam logic [13:0] CFG_WORDS = 14'h0080;
  localparam logic [13:0] PT_WBASE  = 14'h1000;
  localparam logic [13:0] PT_WORDS  = 14'h03C0;
  localparam int          CTRL_SECURE_BIT = 0;
  localparam logic [15:0] SIG_RST   = 16'h0000;
  localparam logic [31:0] WORD_RST  = 32'h0000_0000;
  localparam logic [7:0]  SEL_RST   = 8'h00;

  typedef enum logic [1:0] {CML_XOR_LOW = 2'b00, CML_XOR_HIGH = 2'b01,
    CML_XOR_PT = 2'b10, CML_XOR_RSV = 2'b11} cml_xor_sel_t;
  typedef enum logic [1:0] {CML_D_XOR = 2'b00, CML_D_PT = 2'b01,
    CML_D_PIN = 2'b10, CML_D_RSV = 2'b11} cml_d_src_t;
  typedef enum logic [1:0] {CML_FF_D = 2'b00, CML_FF_T = 2'b01,
    CML_FF_JK = 2'b10, CML_FF_SR = 2'b11} cml_ff_mode_t;
  typedef enum logic [1:0] {CML_RST_OFF = 2'b00, CML_RST_GCLR = 2'b01,
    CML_RST_PT = 2'b10, CML_RST_BOTH = 2'b11} cml_rst_sel_t;
  typedef enum logic [2:0] {CML_OE_OFF = 3'b000, CML_OE_ON = 3'b001,
    CML_OE_PIN = 3'b010, CML_OE_PIN_N = 3'b011, CML_OE_IO = 3'b100,
    CML_OE_IO_N = 3'b101, CML_OE_MC = 3'b110,
    CML_OE_MC_N = 3'b111} cml_oe_src_t;

  // Two config words per macrocell, {word1, word0}, first field on top.
  typedef struct packed {
    logic [7:0]   pad;
    logic [4:0]   or_en;
    logic         casc_en;
    cml_xor_sel_t xor_sel;
    logic [2:0]   xor_pt;
    cml_d_src_t   d_src;
    logic [2:0]   d_pt;
    cml_ff_mode_t ff_mode;
    logic         latch;
    logic [2:0]   aux_pt;
    logic [2:0]   clk_src;
    logic [2:0]   clk_pt;
    logic         ce_en;
    cml_rst_sel_t async_reset_select;
    logic [2:0]   rst_pt;
    logic [1:0]   gclr_pin;
    logic         async_preset_select;
    logic [2:0]   preset_pt;
    logic         out_reg;
    logic         fb_reg;
    logic [2:0]   fold_pt;
    cml_oe_src_t  oe_src;
    logic [5:0]   oe_idx;
    logic [1:0]   oe_pin;
  } cml_cfg_t;

  typedef struct packed {
    logic chain;
    logic fold;
    logic comb;
    logic q;
    logic fb;
    logic out;
  } cml_mc_out_t;
endpackage : cml_pkg

/* File: cml_top.sv */
// Top of the macrocell array model with its configuration register file.
// Assumes a Wishbone classic master on clk_sys and pins from the board,
// which are synchronised here before any logic looks at them.
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module cml_top
  import cml_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [15:0]         wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic [NUM_DED-1:0]  ded_pin,
  input  wire logic [NUM_IO-1:0]   io_in,
  output logic      [NUM_IO-1:0]   io_out,
  output logic      [NUM_IO-1:0]   io_oe
);

  // Byte-lane merge for partial writes.
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = new_w[i*8 +: 8];
    end
    return r;
  endfunction : lane_merge

  // Output enable source chosen per macrocell.
  function automatic logic oe_pick(input cml_cfg_t c,
                                   input logic [NUM_DED-1:0] dd,
                                   input logic [NUM_IO-1:0] pins,
                                   input logic [NUM_MC-1:0] fbs);
    logic r;
    r = 1'b0;
    unique case (c.oe_src)
      CML_OE_OFF:   r = 1'b0;
      CML_OE_ON:    r = 1'b1;
      CML_OE_PIN:   r = dd[c.oe_pin];
      CML_OE_PIN_N: r = ~dd[c.oe_pin];
      CML_OE_IO:    r = pins[c.oe_idx];
      CML_OE_IO_N:  r = ~pins[c.oe_idx];
      CML_OE_MC:    r = fbs[c.oe_idx];
      CML_OE_MC_N:  r = ~fbs[c.oe_idx];
    endcase
    return r;
  endfunction : oe_pick

  logic [NUM_DED-1:0] ded_s1, ded_s;
  logic [NUM_IO-1:0]  io_s1, io_s;
  logic [GBUS_W-1:0]  gbus;
  logic [NUM_MC-1:0]  fold_all, fold_r, fb_all, out_all, oe_all, chain;
  logic [15:0]        sig;
  logic               secure;
  logic [7:0]         sw_sel  [0:SW_SEL*NUM_BLK-1];
  logic [31:0]        cfg_mem [0:2*NUM_MC-1];
  logic [31:0]        pt_mem  [0:PT_WPM*NUM_MC-1];
  logic [SW_SEL-1:0]  sw_bus  [0:NUM_BLK-1];
  cml_cfg_t           cfg_v   [0:NUM_MC-1];
  cml_mc_out_t        res     [0:NUM_MC-1];

  logic        req, wr_en;
  logic [13:0] wa, sw_i, cfg_i, pt_i;
  logic        sw_hit, cfg_hit, pt_hit;
  logic [31:0] rd;

  // Two-stage synchronisers; only the second stage feeds any logic.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ded_s1 <= '0;
      ded_s  <= '0;
      io_s1  <= '0;
      io_s   <= '0;
    end else begin
      ded_s1 <= ded_pin;
      ded_s  <= ded_s1;
      io_s1  <= io_in;
      io_s   <= io_s1;
    end
  end

  // Bus registers break every feedback loop through the array, so a
  // combinational feedback appears one clk_sys cycle later.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gbus   <= '0;
      fold_r <= '0;
    end else begin
      gbus   <= {ded_s, fb_all, io_s};
      fold_r <= fold_all;
    end
  end

  // Wishbone classic decode.
  assign req     = wb_cyc_i & wb_stb_i;
  assign wr_en   = req & wb_we_i & wb_ack_o;
  assign wa      = wb_adr_i[15:2];
  assign sw_i    = wa - SW_WBASE;
  assign cfg_i   = wa - CFG_WBASE;
  assign pt_i    = wa - PT_WBASE;
  assign sw_hit  = (wa >= SW_WBASE) && (sw_i < SW_WORDS);
  assign cfg_hit = (wa >= CFG_WBASE) && (cfg_i < CFG_WORDS);
  assign pt_hit  = (wa >= PT_WBASE) && (pt_i < PT_WORDS);

  // One wait cycle per access; ack drops the cycle after it is given.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) wb_ack_o <= 1'b0;
    else wb_ack_o <= req & ~wb_ack_o;
  end

  // Read data is captured as ack rises and stands while ack is high.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) wb_dat_o <= WORD_RST;
    else if (req && !wb_ack_o) wb_dat_o <= rd;
  end

  // Signature and security bit; security only sets, reset clears it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sig    <= SIG_RST;
      secure <= 1'b0;
    end else if (wr_en && wa == SIG_W) begin
      sig <= 16'(lane_merge({16'h0000, sig}, wb_dat_i, wb_sel_i));
    end else if (wr_en && wa == CTRL_W && wb_sel_i[0] &&
                 wb_dat_i[CTRL_SECURE_BIT]) begin
      secure <= 1'b1;
    end
  end

  // Switch matrix selections, one byte-wide index per word.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < SW_SEL*NUM_BLK; i++) sw_sel[i] <= SEL_RST;
    end else if (wr_en && sw_hit && wb_sel_i[0]) begin
      sw_sel[sw_i[7:0]] <= wb_dat_i[7:0];
    end
  end

  // Macrocell configuration words.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 2*NUM_MC; i++) cfg_mem[i] <= WORD_RST;
    end else if (wr_en && cfg_hit) begin
      cfg_mem[cfg_i[6:0]] <= lane_merge(cfg_mem[cfg_i[6:0]], wb_dat_i,
                                        wb_sel_i);
    end
  end

  // Product term masks: three words per term, true columns low.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < PT_WPM*NUM_MC; i++) pt_mem[i] <= WORD_RST;
    end else if (wr_en && pt_hit) begin
      pt_mem[pt_i[9:0]] <= lane_merge(pt_mem[pt_i[9:0]], wb_dat_i,
                                      wb_sel_i);
    end
  end

  // Read mux; configuration reads as zero once security is set, but the
  // signature stays visible so boards can still be identified.
  always_comb begin
    rd = WORD_RST;
    if (wa == SIG_W) rd = {16'h0000, sig};
    else if (wa == CTRL_W) rd = {31'h0000_0000, secure};
    else if (wa == DED_W) rd = {28'h000_0000, ded_s};
    else if (wa == IO_LO_W) rd = io_s[31:0];
    else if (wa == IO_HI_W) rd = io_s[63:32];
    else if (wa == FB_LO_W) rd = fb_all[31:0];
    else if (wa == FB_HI_W) rd = fb_all[63:32];
    else if (!secure) begin
      if (sw_hit) rd = {24'h00_0000, sw_sel[sw_i[7:0]]};
      else if (cfg_hit) rd = cfg_mem[cfg_i[6:0]];
      else if (pt_hit) rd = pt_mem[pt_i[9:0]];
    end
  end

  // Per-block switch matrix; an index past the bus reads as zero.
  for (genvar b = 0; b < NUM_BLK; b++) begin : g_blk
    for (genvar k = 0; k < SW_SEL; k++) begin : g_sel
      assign sw_bus[b][k] = (sw_sel[b*SW_SEL+k] <= GBUS_MAX) ?
                            gbus[sw_sel[b*SW_SEL+k]] : 1'b0;
    end
  end

  // Macrocell array.
  for (genvar m = 0; m < NUM_MC; m++) begin : g_mc
    localparam int BLK = m / MC_PER_BLK;
    localparam int RGN = m / REG_MC;
    logic [NUM_PT*PT_STRIDE-1:0] mk;
    logic                        cin;
    assign cfg_v[m] = {cfg_mem[2*m+1], cfg_mem[2*m]};
    for (genvar w = 0; w < PT_WPM; w++) begin : g_w
      assign mk[w*32 +: 32] = pt_mem[m*PT_WPM+w];
    end
    // Chains restart every CHAIN_LEN cells, capping the sum at 40 terms.
    if (m % CHAIN_LEN == 0) begin : g_head
      assign cin = 1'b0;
    end else begin : g_link
      assign cin = chain[m-1];
    end
    cml_macrocell u_mc (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .cfg      (cfg_v[m]),
      .blk_in   ({fold_r[RGN*REG_MC +: REG_MC], sw_bus[BLK]}),
      .masks    (mk),
      .ded      (ded_s),
      .pin      (io_s[m]),
      .chain_in (cin),
      .res      (res[m])
    );
    assign chain[m]    = res[m].chain;
    assign fold_all[m] = res[m].fold;
    assign fb_all[m]   = res[m].fb;
    assign out_all[m]  = res[m].out;
    assign oe_all[m]   = oe_pick(cfg_v[m], ded_s, io_s, fb_all);
  end

  // Pin drivers come from flip-flops; reset leaves every pin undriven.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      io_out <= '0;
      io_oe  <= '0;
    end else begin
      io_out <= out_all;
      io_oe  <= oe_all;
    end
  end

  chk_ack_next: assert property (@(posedge clk_sys) disable iff (!rst_n)
    req && !wb_ack_o |=> wb_ack_o) else $error("bus access not answered");
  chk_ack_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
  chk_sig_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (req && !wb_ack_o && !wb_we_i && wa == SIG_W)
    |=> wb_ack_o && wb_dat_o == {16'h0000, $past(sig)})
    else $error("signature read returned wrong data");
  chk_secure_hide: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (req && !wb_ack_o && !wb_we_i && secure && (cfg_hit || pt_hit))
    |=> wb_dat_o == WORD_RST) else $error("protected data was readable");
  chk_oe_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_v[0].oe_src == CML_OE_OFF |=> !io_oe[0])
    else $error("pin driven while output enable is off");
  chk_comb_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !cfg_v[0].out_reg |=> io_out[0] == $past(res[0].comb))
    else $error("combinational output not passed to pin");
  cov_secure_sig: cover property (@(posedge clk_sys) disable iff (!rst_n)
    secure && wb_ack_o && !wb_we_i && wa == SIG_W);
  cov_pt_write: cover property (@(posedge clk_sys) disable iff (!rst_n)
    wr_en && pt_hit);
  cov_pin_drive: cover property (@(posedge clk_sys) disable iff (!rst_n)
    io_oe[0] && io_out[0]);
endmodule : cml_top

/* File: cml_top_bench.sv */
// Self-checking bench for the macrocell array with its register bus.
// Assumes the board model drives every pin the array does not drive.
`timescale 1ns/1ps
module cml_top_bench
  import cml_pkg::*;
;
  typedef struct packed {
    logic        we;
    logic [15:0] a;
    logic [31:0] d;
    logic [3:0]  s;
    logic [31:0] e;
  } cml_row_t;

  localparam cml_row_t ROWS [9] = '{
    '{1'b0, 16'h0000, 32'h0, 4'h0, 32'h0},
    '{1'b1, 16'h0000, 32'h0000_A5C3, 4'hF, 32'h0},
    '{1'b0, 16'h0000, 32'h0, 4'h0, 32'h0000_A5C3},
    '{1'b1, 16'h0000, 32'h0000_00FF, 4'h1, 32'h0},
    '{1'b0, 16'h0000, 32'h0, 4'h0, 32'h0000_A5FF},
    '{1'b0, 16'h0100, 32'h0, 4'h0, 32'h0},
    '{1'b1, 16'h0008, 32'hFFFF_FFFF, 4'hF, 32'h0},
    '{1'b0, 16'h0008, 32'h0, 4'h0, 32'h0},
    '{1'b0, 16'h0004, 32'h0, 4'h0, 32'h0}};

  logic               clk_sys;
  logic               rst_n;
  logic               wb_cyc_i;
  logic               wb_stb_i;
  logic               wb_we_i;
  logic [15:0]        wb_adr_i;
  logic [3:0]         wb_sel_i;
  logic [31:0]        wb_dat_i;
  logic [31:0]        wb_dat_o;
  logic               wb_ack_o;
  logic [NUM_DED-1:0] ded_pin;
  logic [NUM_IO-1:0]  io_in;
  logic [NUM_IO-1:0]  io_out;
  logic [NUM_IO-1:0]  io_oe;
  logic [31:0]        rd;
  cml_cfg_t           c;
  int                 n_errors = 0;
  int                 checked = 0;
  int                 cycles = 0;

  cml_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ded_pin(ded_pin), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe));

  cml_board brd (.io_out(io_out), .io_oe(io_oe), .clk_sys(clk_sys),
    .ded_pin(ded_pin), .io_in(io_in));

  // Half period of 2 ns gives the 250 MHz system clock.
  initial clk_sys = 1'b0;
  always #2 clk_sys = ~clk_sys;

  task automatic conclude;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  // A hung handshake must still end the run with a verdict.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Classic single cycle; the request stands until ack is sampled high.
  task automatic wb(input logic we, input logic [15:0] a,
                    input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (n >= 50) chk("wb ack", 64'h1, 64'h0);
  endtask : wb

  task automatic cfg_wr(input cml_cfg_t cf);
    logic [31:0] q;
    wb(1'b1, 16'h2000, cf[31:0], 4'hF, q);
    wb(1'b1, 16'h2004, cf[63:32], 4'hF, q);
  endtask : cfg_wr

  // Pins settle through synchroniser and array within a few cycles.
  task automatic wait_bit(input string nm, input int i, input logic oe,
                          input logic e);
    logic v;
    int   n;
    n = 0;
    v = oe ? io_oe[i] : io_out[i];
    while (v !== e && n < 12) begin
      @(posedge clk_sys);
      n++;
      v = oe ? io_oe[i] : io_out[i];
    end
    chk(nm, {63'h0, e}, {63'h0, v});
  endtask : wait_bit

  // Main sequence: reset, register rows, then the logic paths.
  initial begin
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 16'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk("io_out reset", 64'h0, io_out);
    chk("io_oe reset", 64'h0, io_oe);
    foreach (ROWS[k]) begin
      wb(ROWS[k].we, ROWS[k].a, ROWS[k].d, ROWS[k].s, rd);
      if (!ROWS[k].we) chk("reg read", {32'h0, ROWS[k].e}, {32'h0, rd});
    end
    wb(1'b1, 16'h1000, 32'h0000_0005, 4'h1, rd);
    wb(1'b1, 16'h4000, 32'h0000_0001, 4'hF, rd);
    c = '0;
    c.or_en = 5'h01;
    c.oe_src = CML_OE_ON;
    cfg_wr(c);
    brd.set_io(5, 1'b1);
    wait_bit("comb out", 0, 1'b0, 1'b1);
    wait_bit("oe on", 0, 1'b1, 1'b1);
    wb(1'b0, 16'h0018, 32'h0, 4'h0, rd);
    chk("feedback", 64'h1, {32'h0, rd});
    // Cell 1 sums nothing locally, so its output is cell 0's chained sum.
    wb(1'b1, 16'h2008, 32'h0000_0100, 4'hF, rd);
    wb(1'b1, 16'h200C, 32'h0004_0000, 4'hF, rd);
    wait_bit("chain out", 1, 1'b0, 1'b1);
    c.xor_sel = CML_XOR_HIGH;
    cfg_wr(c);
    wait_bit("inverted out", 0, 1'b0, 1'b0);
    c.xor_sel = CML_XOR_LOW;
    c.out_reg = 1'b1;
    cfg_wr(c);
    repeat (10) @(posedge clk_sys);
    chk("held without clock", 64'h0, {63'h0, io_out[0]});
    brd.pulse(0);
    wait_bit("clocked out", 0, 1'b0, 1'b1);
    c.async_reset_select = CML_RST_GCLR;
    c.gclr_pin = 2'h1;
    cfg_wr(c);
    brd.set_ded(1, 1'b1);
    wait_bit("global clear", 0, 1'b0, 1'b0);
    c.async_preset_select = 1'b1;
    cfg_wr(c);
    repeat (10) @(posedge clk_sys);
    chk("clear over preset", 64'h0, {63'h0, io_out[0]});
    brd.set_ded(1, 1'b0);
    wait_bit("term preset", 0, 1'b0, 1'b1);
    c.async_preset_select = 1'b0;
    c.async_reset_select = CML_RST_OFF;
    c.ff_mode = CML_FF_T;
    cfg_wr(c);
    brd.pulse(0);
    wait_bit("toggle low", 0, 1'b0, 1'b0);
    brd.pulse(0);
    wait_bit("toggle high", 0, 1'b0, 1'b1);
    c.oe_src = CML_OE_PIN_N;
    c.oe_pin = 2'h2;
    cfg_wr(c);
    wait_bit("oe pin low", 0, 1'b1, 1'b1);
    brd.set_ded(2, 1'b1);
    wait_bit("oe pin high", 0, 1'b1, 1'b0);
    // Term 1 is the inverse of column 0, so it is low while pin 5 is high.
    wb(1'b1, 16'h4010, 32'h0000_1000, 4'hF, rd);
    c.ff_mode = CML_FF_D;
    c.xor_sel = CML_XOR_HIGH;
    c.ce_en = 1'b1;
    c.clk_pt = 3'h1;
    cfg_wr(c);
    brd.pulse(0);
    chk("edge ignored", 64'h1, {63'h0, io_out[0]});
    c.clk_pt = 3'h2;
    cfg_wr(c);
    brd.pulse(0);
    wait_bit("edge enabled", 0, 1'b0, 1'b0);
    // Latch holds while the clock is low and follows data while high.
    c.latch = 1'b1;
    c.xor_sel = CML_XOR_LOW;
    cfg_wr(c);
    repeat (8) @(posedge clk_sys);
    chk("latch closed", 64'h0, {63'h0, io_out[0]});
    brd.set_ded(0, 1'b1);
    wait_bit("latch open", 0, 1'b0, 1'b1);
    brd.set_ded(0, 1'b0);
    // Secure hides configuration but never the signature.
    wb(1'b1, 16'h2008, 32'h0000_1234, 4'hF, rd);
    wb(1'b0, 16'h2008, 32'h0, 4'h0, rd);
    chk("cfg open", 64'h1234, {32'h0, rd});
    wb(1'b1, 16'h0004, 32'h0000_0001, 4'hF, rd);
    wb(1'b0, 16'h2008, 32'h0, 4'h0, rd);
    chk("cfg hidden", 64'h0, {32'h0, rd});
    wb(1'b0, 16'h0000, 32'h0, 4'h0, rd);
    chk("sig secure", 64'hA5FF, {32'h0, rd});
    // Reset in mid-run must clear outputs, security and the signature.
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk("io_out rerun", 64'h0, io_out);
    chk("io_oe rerun", 64'h0, io_oe);
    wb(1'b0, 16'h0004, 32'h0, 4'h0, rd);
    chk("secure cleared", 64'h0, {32'h0, rd});
    wb(1'b0, 16'h0000, 32'h0, 4'h0, rd);
    chk("sig cleared", 64'h0, {32'h0, rd});
    conclude();
  end
endmodule : cml_top_bench
